// *** src/lsl_led_top.sv ***
// Status lamp driver for the fieldbus option board
// Notes on behaviour
// R01: Refresh lamp lights on each correctly received refresh frame.
// R02: Refresh lamp goes off after the refresh timeout without frames.
// R03: Error lamp steady while a communication error is present.
// R04: Error lamp flashes if station, baud or switch setting changes while powered.
// R05: Operator cycles power or asserts drive reset to apply settings, stop flashing.
// R06: Alive lamp steady during normal operation, even without traffic.
// R07: Alive lamp flashes when configured version 2 but master is version 1.
// R08: Transmit lamp off once no data has been sent for the TXHOLD_CYC hold count.
// R09: Carrier lamp lit while carrier detected on incoming line.
// R10: Timeout and flash rate are parameter counts; timeout restarts per frame.
`timescale 1ns/100ps
module lsl_led_top #(
    parameter int unsigned REFRESH_CYC = lsl_pkg::REFRESH_TMO_CYC,
    parameter int unsigned FLASH_CYC   = lsl_pkg::FLASH_HALF_CYC,
    parameter int unsigned TXHOLD_CYC  = lsl_pkg::TX_HOLD_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        drive_reset_input,
    input  wire logic        refreshOk,
    input  wire logic        commError,
    input  wire logic        txActive,
    input  wire logic        carrierDetect,
    input  wire logic        masterVer1,
    input  wire logic        cfgVer2,
    input  wire logic [7:0]  station_number_setting,
    input  wire logic [7:0]  baud_rate_setting,
    input  wire logic [7:0]  boardSwitch,
    output logic             linkRunLed,
    output logic             linkErrLed,
    output logic             aliveLed,
    output logic             transmit_activity_led,
    output logic             rxCarrierLed
);
    typedef enum logic [2:0] {
        ST_INIT  = 3'b001,
        ST_RUN   = 3'b010,
        ST_DIRTY = 3'b100
    } lsl_state_e;

    lsl_state_e  state_r;
    logic [5:0]  syncPins;
    logic        drvRstS;
    logic        refreshS;
    logic        errS;
    logic        txS;
    logic        carS;
    logic        mv1S;
    logic        refreshD_r;
    logic        refreshPulse;
    logic [31:0] tmoCnt_r;
    logic [31:0] flashCnt_r;
    logic        flash_r;
    logic [31:0] txCnt_r;
    logic [7:0]  stnIn1_r;
    logic [7:0]  stnIn2_r;
    logic [7:0]  baudIn1_r;
    logic [7:0]  baudIn2_r;
    logic [7:0]  swIn1_r;
    logic [7:0]  swIn2_r;
    logic [7:0]  stnHeld_r;
    logic [7:0]  baudHeld_r;
    logic [7:0]  swHeld_r;
    logic        cfgChanged;
    logic [1:0]  syncFill_r;

    // Bring single-bit pins into the clock domain
    lsl_sync #(.WIDTH(lsl_pkg::SYNC_WIDTH)) u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .asyncIn ({drive_reset_input, refreshOk, commError, txActive, carrierDetect,
                   masterVer1}),
        .syncOut (syncPins)
    );
    assign {drvRstS, refreshS, errS, txS, carS, mv1S} = syncPins;

    // Setting buses through their own two-stage synchronisers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stnIn1_r  <= lsl_pkg::SETTING_RESET;
            stnIn2_r  <= lsl_pkg::SETTING_RESET;
            baudIn1_r <= lsl_pkg::SETTING_RESET;
            baudIn2_r <= lsl_pkg::SETTING_RESET;
            swIn1_r   <= lsl_pkg::SETTING_RESET;
            swIn2_r   <= lsl_pkg::SETTING_RESET;
        end else begin
            stnIn1_r  <= station_number_setting;
            stnIn2_r  <= stnIn1_r;
            baudIn1_r <= baud_rate_setting;
            baudIn2_r <= baudIn1_r;
            swIn1_r   <= boardSwitch;
            swIn2_r   <= swIn1_r;
        end
    end

    // Marks the setting synchronisers as holding pin values after reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            syncFill_r <= 2'b00;
        end else begin
            syncFill_r <= {syncFill_r[0], 1'b1};
        end
    end

    assign cfgChanged = (stnIn2_r != stnHeld_r) || (baudIn2_r != baudHeld_r) ||
                        (swIn2_r != swHeld_r);

    // Settings captured after reset; changes later mark the board dirty
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r    <= ST_INIT;
            stnHeld_r  <= lsl_pkg::SETTING_RESET;
            baudHeld_r <= lsl_pkg::SETTING_RESET;
            swHeld_r   <= lsl_pkg::SETTING_RESET;
        end else begin
            case (state_r)
                ST_INIT: begin
                    stnHeld_r  <= stnIn2_r;
                    baudHeld_r <= baudIn2_r;
                    swHeld_r   <= swIn2_r;
                    // Leave only once the synchronisers no longer show reset values
                    if (syncFill_r[1]) begin
                        state_r <= ST_RUN; // [R04]
                    end
                end
                ST_RUN: begin
                    if (drvRstS) begin
                        state_r <= ST_INIT;
                    end else if (cfgChanged) begin
                        state_r <= ST_DIRTY; // [R04]
                    end
                end
                ST_DIRTY: begin
                    if (drvRstS) begin
                        state_r <= ST_INIT; // [R05]
                    end
                end
                default: begin
                    state_r <= ST_INIT;
                end
            endcase
        end
    end

    // Rising edge of the frame-good strobe
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            refreshD_r <= 1'b0;
        end else begin
            refreshD_r <= refreshS;
        end
    end
    assign refreshPulse = refreshS && !refreshD_r;

    // Refresh timeout, reloaded on every good frame
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tmoCnt_r   <= 32'h0000_0000;
            linkRunLed <= 1'b0;
        end else if (refreshPulse) begin
            tmoCnt_r   <= REFRESH_CYC; // [R10]
            linkRunLed <= 1'b1; // [R01]
        end else if (tmoCnt_r > 32'h0000_0001) begin
            tmoCnt_r <= tmoCnt_r - 32'h0000_0001;
        end else begin
            tmoCnt_r   <= 32'h0000_0000;
            linkRunLed <= 1'b0; // [R02]
        end
    end

    // Free-running flash square wave
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            flashCnt_r <= 32'h0000_0000;
            flash_r    <= 1'b0;
        end else if (flashCnt_r >= FLASH_CYC - 1) begin
            flashCnt_r <= 32'h0000_0000; // [R10]
            flash_r    <= !flash_r;
        end else begin
            flashCnt_r <= flashCnt_r + 32'h0000_0001;
        end
    end

    // Transmit lamp stretched so short bursts stay visible
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            txCnt_r               <= 32'h0000_0000;
            transmit_activity_led <= 1'b0;
        end else if (txS) begin
            txCnt_r               <= TXHOLD_CYC;
            transmit_activity_led <= 1'b1;
        end else if (txCnt_r > 32'h0000_0001) begin
            txCnt_r <= txCnt_r - 32'h0000_0001;
        end else begin
            txCnt_r               <= 32'h0000_0000;
            transmit_activity_led <= 1'b0; // [R08]
        end
    end

    // Error, alive and carrier lamps
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            linkErrLed   <= 1'b0;
            aliveLed     <= 1'b0;
            rxCarrierLed <= 1'b0;
        end else begin
            if (state_r == ST_DIRTY) begin
                linkErrLed <= flash_r; // [R04]
            end else begin
                linkErrLed <= errS; // [R03]
            end
            if (cfgVer2 && mv1S) begin
                aliveLed <= flash_r; // [R07]
            end else begin
                aliveLed <= 1'b1; // [R06]
            end
            rxCarrierLed <= carS; // [R09]
        end
    end

    // Checks
    chk_refresh_lights: assert property (@(posedge ref_clk) disable iff (!resetn)
        refreshPulse |=> linkRunLed) else $error("refresh lamp not lit"); // [R01]
    chk_refresh_timeout: assert property (@(posedge ref_clk) disable iff (!resetn)
        (linkRunLed && !refreshPulse && tmoCnt_r == 32'h0000_0001) |=> !linkRunLed)
        else $error("refresh lamp not timed out"); // [R02]
    chk_err_steady: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_r != ST_DIRTY) |=> (linkErrLed == $past(errS)))
        else $error("error lamp wrong"); // [R03]
    chk_dirty_entry: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_r == ST_RUN && cfgChanged && !drvRstS) |=> state_r == ST_DIRTY)
        else $error("setting change missed"); // [R04]
    chk_dirty_flash: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_r == ST_DIRTY) |=> (linkErrLed == $past(flash_r)))
        else $error("error lamp not flashing"); // [R04]
    chk_reset_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state_r == ST_DIRTY && drvRstS) |=> state_r == ST_INIT)
        else $error("drive reset ignored"); // [R05]
    chk_alive_steady: assert property (@(posedge ref_clk) disable iff (!resetn)
        !(cfgVer2 && mv1S) |=> aliveLed) else $error("alive lamp off"); // [R06]
    chk_alive_flash: assert property (@(posedge ref_clk) disable iff (!resetn)
        (cfgVer2 && mv1S) |=> aliveLed == $past(flash_r))
        else $error("alive lamp not flashing"); // [R07]
    chk_tx_off: assert property (@(posedge ref_clk) disable iff (!resetn)
        (txCnt_r == 32'h0000_0000 && !txS) |=> !transmit_activity_led)
        else $error("tx lamp on while idle"); // [R08]
    chk_carrier_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
        ##1 rxCarrierLed == $past(carS)) else $error("carrier lamp wrong"); // [R09]
    chk_flash_period: assert property (@(posedge ref_clk) disable iff (!resetn)
        flashCnt_r < FLASH_CYC) else $error("flash counter overran"); // [R10]

    cov_refresh: cover property (@(posedge ref_clk) disable iff (!resetn)
        refreshPulse ##1 linkRunLed);
    cov_timeout: cover property (@(posedge ref_clk) disable iff (!resetn)
        $fell(linkRunLed));
    cov_dirty: cover property (@(posedge ref_clk) disable iff (!resetn)
        state_r == ST_RUN ##1 state_r == ST_DIRTY);
    cov_version: cover property (@(posedge ref_clk) disable iff (!resetn)
        cfgVer2 && mv1S && $fell(aliveLed));
endmodule : lsl_led_top

// *** include/lsl_pkg.sv ***
// Package of constants for the link status lamp logic
package lsl_pkg;
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned REFRESH_TMO_MS   = 100;
    localparam int unsigned REFRESH_TMO_CYC  = REFRESH_TMO_MS * 1000 * CLK_MHZ;
    localparam int unsigned FLASH_HALF_MS    = 250;
    localparam int unsigned FLASH_HALF_CYC   = FLASH_HALF_MS * 1000 * CLK_MHZ;
    localparam int unsigned TX_HOLD_US       = 10;
    localparam int unsigned TX_HOLD_CYC      = TX_HOLD_US * CLK_MHZ;
    localparam int unsigned SYNC_WIDTH       = 6;
    localparam logic [5:0]  SYNC_RESET       = 6'h00;
    localparam int unsigned SETTING_WIDTH    = 8;
    localparam logic [7:0]  SETTING_RESET    = 8'h00;
endpackage : lsl_pkg

// *** src/lsl_sync.sv ***
// Two-stage synchroniser bank for asynchronous pin inputs
`timescale 1ns/100ps
module lsl_sync #(
    parameter int unsigned WIDTH = 6
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;

    // Each bit passes two flip-flops
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    stage1_r[gi] <= 1'b0;
                    syncOut[gi]  <= 1'b0;
                end else begin
                    stage1_r[gi] <= asyncIn[gi];
                    syncOut[gi]  <= stage1_r[gi];
                end
            end
        end
    endgenerate
endmodule : lsl_sync

// *** tb/lsl_master_model.sv ***
// Behavioural master station: periodic refresh frames and version report
`timescale 1ns/100ps
module lsl_master_model (
    input  wire logic       ref_clk,
    input  wire logic       enable,
    input  wire logic [7:0] gap,
    input  wire logic       onlyVer1,
    output logic            refreshOk,
    output logic            masterVer1
);
    logic [7:0] cntR = 8'h00;
    initial refreshOk = 1'b0;
    // Two-cycle frame strobe every gap+1 cycles, quiet when disabled
    always @(negedge ref_clk) begin
        if (!enable) begin
            cntR <= 8'h00;
            refreshOk <= 1'b0;
        end else begin
            cntR <= (cntR >= gap) ? 8'h00 : cntR + 8'h01;
            refreshOk <= (cntR < 8'h02);
        end
    end
    assign masterVer1 = onlyVer1; // Master capability level
endmodule : lsl_master_model

// *** tb/lsl_led_top_tb.sv ***
// Self-checking bench for the status lamp driver
`timescale 1ns/100ps
module lsl_led_top_tb;
    localparam int RCYC = 50;
    localparam int FCYC = 8;
    localparam int TCYC = 4;
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       drvRst = 1'b0;
    logic       commError = 1'b0;
    logic       txActive = 1'b0;
    logic       carrierDetect = 1'b0;
    logic       cfgVer2 = 1'b0;
    logic       mEn = 1'b0;
    logic       onlyV1 = 1'b0;
    logic [7:0] stn = 8'h00;
    logic [7:0] baud = 8'h00;
    logic [7:0] sw = 8'h00;
    logic [7:0] gap = 8'h14;
    wire        refreshOk;
    wire        masterVer1;
    wire  [4:0] leds;
    int         errorCnt = 0;
    int         checkCount = 0;
    int         tog;
    int         ones;
    int         k;

    always #2.5 ref_clk = ~ref_clk;

    lsl_master_model i_lsl_master_model (.ref_clk(ref_clk), .enable(mEn), .gap(gap),
        .onlyVer1(onlyV1), .refreshOk(refreshOk), .masterVer1(masterVer1));

    lsl_led_top #(.REFRESH_CYC(RCYC), .FLASH_CYC(FCYC), .TXHOLD_CYC(TCYC)) i_lsl_led_top (
        .ref_clk(ref_clk), .resetn(resetn), .drive_reset_input(drvRst),
        .refreshOk(refreshOk), .commError(commError), .txActive(txActive),
        .carrierDetect(carrierDetect), .masterVer1(masterVer1), .cfgVer2(cfgVer2),
        .station_number_setting(stn), .baud_rate_setting(baud), .boardSwitch(sw),
        .linkRunLed(leds[4]), .linkErrLed(leds[3]), .aliveLed(leds[2]),
        .transmit_activity_led(leds[1]), .rxCarrierLed(leds[0]));

    // One fewer than the toggles a flashing lamp shows in n cycles
    function automatic int minTog(input int n);
        return n / FCYC - 1;
    endfunction : minTog

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[ERR] %0t lamp value %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        if (errorCnt == 0 && checkCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // Count changes and lit cycles of one lamp
    task automatic watch(input int idx, input int n);
        logic prev;
        prev = leds[idx];
        tog = 0;
        ones = 0;
        repeat (n) begin
            @(negedge ref_clk);
            if (leds[idx] !== prev) tog++;
            if (leds[idx] === 1'b1) ones++;
            prev = leds[idx];
        end
    endtask : watch

    // Watchdog against hangs
    initial begin
        cyc(20000);
        errorCnt++;
        close_out();
    end

    initial begin
        void'($urandom(76840));
        stn = 8'($urandom);
        baud = 8'($urandom);
        sw = 8'($urandom);
        cyc(20);
        resetn = 1'b1;
        cyc(6);
        chk(leds, 5'h04);
        // Carrier and error lamps follow random levels
        for (k = 0; k < 12; k++) begin
            carrierDetect = 1'($urandom);
            commError = 1'($urandom);
            cyc(4);
            chk(leds[0], carrierDetect);
            chk(leds[3], commError);
        end
        commError = 1'b0;
        // Refresh frames, then silence
        mEn = 1'b1;
        k = 0;
        while (leds[4] !== 1'b1 && k < 40) begin
            cyc(1);
            k++;
        end
        chk(leds[4], 1'b1);
        watch(4, 150);
        chk(8'(ones), 8'd150);
        mEn = 1'b0;
        cyc(RCYC - 25);
        chk(leds[4], 1'b1);
        cyc(35);
        chk(leds[4], 1'b0);
        // Transmit lamp stretch and release
        txActive = 1'b1;
        cyc(4);
        chk(leds[1], 1'b1);
        txActive = 1'b0;
        cyc(TCYC + 6);
        chk(leds[1], 1'b0);
        // Each setting bus changed while powered, then drive reset
        for (k = 0; k < 3; k++) begin
            if (k == 0) stn = ~stn;
            if (k == 1) baud = ~baud;
            if (k == 2) sw = ~sw;
            cyc(6);
            watch(3, 5 * FCYC);
            chk(8'(tog >= minTog(5 * FCYC)), 8'h01);
            drvRst = 1'b1;
            cyc(4);
            drvRst = 1'b0;
            cyc(8);
            watch(3, 4 * FCYC);
            chk(8'(tog + ones), 8'h00);
        end
        // Version mismatch flashes, match stays steady
        cfgVer2 = 1'b1;
        onlyV1 = 1'b1;
        cyc(6);
        watch(2, 5 * FCYC);
        chk(8'(tog >= minTog(5 * FCYC)), 8'h01);
        onlyV1 = 1'b0;
        cyc(6);
        watch(2, 4 * FCYC);
        chk(8'(ones), 8'(4 * FCYC));
        close_out();
    end
endmodule : lsl_led_top_tb
